/* File: rtl/slp_strap_led.sv */
// Strap latch, LED pin drivers, spare I/O, interrupt pin and capability-limited registers
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ns
module slp_strap_led import slp_pkg::*; #(
    parameter int          BLINK_COUNT = BLINK_CYC,
    parameter logic [31:0] CAP_TABLE   = 32'hFFFF_FFFF,
    parameter logic [63:0] BICOLOR_TAB = 64'hFFFF_FFFF_5A5A_A5A5
) (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    // Register port
    input  wire logic [4:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    // Pins, input side
    input  wire slp_pins_t   PINS_IN,
    // Shared strap pins, drive side {spare1, rx, col, fast, slow}
    output logic      [4:0]  PINS_OUT,
    output logic      [4:0]  PINS_OE,
    // Plain LED outputs and reference clock output
    output logic             TRANSMIT_LED,
    output logic             DUPLEX_LED,
    output logic             LINK_LED,
    output logic             REFCLK_OUT,
    // Interrupt pin
    output logic             IRQ_OUT,
    output logic             IRQ_OE,
    // Datapath side
    input  wire slp_stat_t   STAT,
    input  wire logic [7:0]  IRQ_EVENTS,
    output slp_cfg_t         CFG
);
    slp_pins_t   pins_s1_q, pins_s2_q, strap_q;
    logic [1:0]  wait_q;
    logic        done_q;
    logic [15:0] misc_q;
    logic [7:0]  irq_en_q, irq_pend_q;
    logic        an_q, spd_q, dpx_q;
    logic [3:0]  adv_q, abil;
    logic [15:0] rdata_d;
    logic [31:0] blink_cnt_q;
    logic        phase_q;
    logic [1:0]  div_q;
    logic [4:0]  out_d;
    logic [3:0]  bic;
    logic        irq_act;

    // Two-flop synchroniser for all pins
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pins_s1_q <= '0;
            pins_s2_q <= '0;
        end else begin
            pins_s1_q <= PINS_IN;
            pins_s2_q <= pins_s1_q;
        end
    end

    // Strap capture once the synchroniser holds real pin levels
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wait_q  <= 2'h0;
            done_q  <= 1'b0;
            strap_q <= '0;
        end else if (!done_q) begin
            if (wait_q == STRAP_WAIT) begin
                strap_q <= pins_s2_q;
                done_q  <= 1'b1;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end

    // Strapped abilities from the capability table
    always_comb begin
        abil = CAP_TABLE[strap_q.cap_sel*4 +: 4];
    end

    // Misc register: repeater, polarity, spare pin direction and data
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            misc_q <= MISC_RESET;
        end else if (REG_WR && REG_ADDR == ADDR_MISC) begin
            misc_q <= REG_WDATA;
        end else if (done_q && misc_q[MISC_DIR_BIT]) begin
            misc_q[MISC_DATA_BIT] <= pins_s2_q.spare1;
        end
    end

    // Control and advertisement, clipped to the strapped ceiling
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            an_q  <= 1'b0;
            spd_q <= 1'b0;
            dpx_q <= 1'b0;
            adv_q <= 4'h0;
        end else if (done_q && !$past(done_q, 1)) begin
            an_q  <= strap_q.autoneg_ability_strap;
            spd_q <= abil[3] | abil[2];
            dpx_q <= abil[3] | abil[1];
            adv_q <= abil;
        end else if (REG_WR && REG_ADDR == ADDR_CTRL) begin
            an_q  <= REG_WDATA[CTRL_AN_BIT] & strap_q.autoneg_ability_strap;
            spd_q <= REG_WDATA[CTRL_SPEED_BIT] & (abil[3] | abil[2]);
            dpx_q <= REG_WDATA[CTRL_DPX_BIT] & (abil[3] | abil[1]);
        end else if (REG_WR && REG_ADDR == ADDR_ADVERT) begin
            adv_q <= REG_WDATA[ADV_ABIL_LSB +: 4] & abil;
        end
    end

    // Interrupt enables and sticky pending; an event beats a clear
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            irq_en_q   <= 8'h00;
            irq_pend_q <= 8'h00;
        end else begin
            if (REG_WR && REG_ADDR == ADDR_IRQ) begin
                irq_en_q   <= REG_WDATA[7:0];
                irq_pend_q <= (irq_pend_q & ~REG_WDATA[15:8]) | IRQ_EVENTS;
            end else begin
                irq_pend_q <= irq_pend_q | IRQ_EVENTS;
            end
        end
    end

    assign irq_act = |(irq_pend_q & irq_en_q);

    // Interrupt pin drive
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            IRQ_OE  <= 1'b0;
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OE  <= irq_act;
            IRQ_OUT <= misc_q[MISC_POL_BIT];
        end
    end

    // Read mux, data stands one cycle after the strobe
    always_comb begin
        rdata_d = 16'h0000;
        unique case (REG_ADDR)
            ADDR_CTRL: begin
                rdata_d[CTRL_AN_BIT]    = an_q;
                rdata_d[CTRL_SPEED_BIT] = spd_q;
                rdata_d[CTRL_DPX_BIT]   = dpx_q;
            end
            ADDR_STATUS: begin
                rdata_d[STAT_ABIL_LSB +: 4] = abil;
                rdata_d[STAT_AN_BIT]        = strap_q.autoneg_ability_strap;
                rdata_d[STAT_LINK_BIT]      = STAT.link_up;
            end
            ADDR_ADVERT: rdata_d[ADV_ABIL_LSB +: 4] = adv_q;
            ADDR_MISC:   rdata_d = misc_q;
            ADDR_IRQ:    rdata_d = {irq_pend_q, irq_en_q};
            default:     rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 16'h0000;
        end else begin
            REG_RDATA <= REG_RD ? rdata_d : 16'h0000;
        end
    end

    // Blink phase for activity LEDs
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            blink_cnt_q <= 32'h0;
            phase_q     <= 1'b0;
        end else if (blink_cnt_q == 32'(BLINK_COUNT - 1)) begin
            blink_cnt_q <= 32'h0;
            phase_q     <= ~phase_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    // Reference clock divider, 100 MHz down to 25 MHz
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            div_q      <= 2'h0;
            REFCLK_OUT <= 1'b0;
        end else begin
            div_q      <= (div_q == REFCLK_DIV_TOP) ? 2'h0 : div_q + 2'h1;
            REFCLK_OUT <= done_q && !strap_q.slow_speed_led && div_q[1];
        end
    end

    // Bicolor pattern lookup
    always_comb begin
        bic = BICOLOR_TAB[{STAT.link_up, STAT.speed100, STAT.full_duplex,
                           STAT.rx_active & phase_q}*4 +: 4];
    end

    // Shared pin output values {spare1, rx, col, fast, slow}
    always_comb begin
        out_d[4] = misc_q[MISC_DATA_BIT];
        out_d[3] = STAT.rx_active ? phase_q : 1'b1;
        out_d[2] = (STAT.collision && !STAT.full_duplex) ? phase_q : 1'b1;
        if (strap_q.receive_led) begin
            out_d[1] = !STAT.speed100;
            out_d[0] = STAT.speed100;
        end else begin
            out_d[1] = bic[3];
            out_d[0] = bic[1];
        end
    end

    // Pin drivers; shared pins float until the straps are latched
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PINS_OUT     <= 5'h00;
            PINS_OE      <= 5'h00;
            TRANSMIT_LED <= 1'b1;
            DUPLEX_LED   <= 1'b1;
            LINK_LED     <= 1'b1;
        end else begin
            PINS_OUT <= out_d;
            PINS_OE  <= {done_q && !misc_q[MISC_DIR_BIT], {4{done_q}}};
            if (strap_q.receive_led) begin
                TRANSMIT_LED <= STAT.tx_active ? phase_q : 1'b1;
                DUPLEX_LED   <= !STAT.full_duplex;
            end else begin
                TRANSMIT_LED <= bic[2];
                DUPLEX_LED   <= bic[0];
            end
            if (STAT.coding_bypass_mode) begin
                LINK_LED <= STAT.signal_detect;
            end else if (STAT.seven_wire) begin
                LINK_LED <= STAT.link_up;
            end else begin
                LINK_LED <= !STAT.link_up;
            end
        end
    end

    // Configuration out
    always_comb begin
        CFG.xfmr_125        = strap_q.spare1;
        CFG.autoneg_en      = an_q;
        CFG.speed100_sel    = spd_q;
        CFG.full_duplex_sel = dpx_q;
        CFG.advert          = adv_q;
        CFG.repeater_mode   = strap_q.repeater_strap | misc_q[MISC_RPT_BIT];
        CFG.scrambler_en    = strap_q.collision_led;
        CFG.fiber_mode      = !strap_q.fast_speed_led;
        CFG.led_advanced    = !strap_q.receive_led;
    end

    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_latched;
        !done_q ##1 done_q;
    endsequence

    sequence s_enabled_pending;
        irq_act;
    endsequence

    a_strap_float_oe: assert property (!done_q |=> PINS_OE == 5'h00)
        else $error("shared pin driven before strap latch");
    a_strap_latch_time: assert property (s_latched |-> $past(wait_q, 1) == STRAP_WAIT)
        else $error("strap latched at wrong cycle");
    a_gpio_input_dir: assert property (done_q && misc_q[MISC_DIR_BIT] && !REG_WR |=> !PINS_OE[4])
        else $error("spare pin driven while input");
    a_gpio_output_val: assert property (done_q && !misc_q[MISC_DIR_BIT] && !REG_WR
                                        |=> PINS_OE[4] && PINS_OUT[4] == $past(misc_q[MISC_DATA_BIT]))
        else $error("spare pin output wrong");
    a_irq_drive_pol: assert property (s_enabled_pending |=> IRQ_OE && IRQ_OUT == $past(misc_q[MISC_POL_BIT]))
        else $error("interrupt not driven at polarity");
    a_irq_float_idle: assert property (!irq_act |=> !IRQ_OE)
        else $error("interrupt driven with nothing pending");
    a_irq_masked_event: assert property ((irq_en_q == 8'h00) && !REG_WR |=> !IRQ_OE)
        else $error("masked event raised interrupt");
    a_cap_autoneg_cap: assert property (done_q |-> !an_q || strap_q.autoneg_ability_strap)
        else $error("autoneg above strap");
    a_cap_advert_cap: assert property (done_q |-> (adv_q & ~abil) == 4'h0)
        else $error("advertised ability above strap");
    a_repeater_mode_or: assert property ($rose(done_q) |-> CFG.repeater_mode ==
        ($past(pins_s2_q.repeater_strap) | misc_q[MISC_RPT_BIT]))
        else $error("repeater mode wrong");
    a_fast_led_std: assert property (done_q && strap_q.receive_led
                                     |=> PINS_OUT[1] == !$past(STAT.speed100))
        else $error("fast speed LED wrong");
    a_duplex_led_std: assert property (strap_q.receive_led |=> DUPLEX_LED == !$past(STAT.full_duplex))
        else $error("duplex LED wrong");
    a_refclk_off_idle: assert property (done_q && strap_q.slow_speed_led |=> !REFCLK_OUT)
        else $error("reference clock active while disabled");
    a_collision_fd_idle: assert property (STAT.full_duplex |=> PINS_OUT[2])
        else $error("collision LED active in full duplex");
endmodule : slp_strap_led

/* File: rtl/slp_pkg.sv */
// Package: constants, pin and status carriers for the strap latch and LED pin block
// How it works
// - Spare pin 1 high at reset release picks 1.25:1 transformer, else 1:1.
// - Direction bit 8 of register 16 set: spare pin 1 is input, level in bit 9.
// - Direction bit 8 clear: spare pin 1 driven with register 16 bit 9.
// - Interrupt pin floats normally, driven at polarity of register 16 bit 14.
// - Only events enabled in register 17 raise the interrupt.
// - Capability pins and autoneg pin latched at reset, shown in registers 1 and 4.
// - Register writes never exceed strapped speed, duplex or autoneg ability.
// - Autoneg pin low at reset disables autoneg, high enables it.
// - Repeater mode on when repeater pin high or register 16 bit 15 set.
// - Receive LED pin low at reset selects advanced LED style.
// - Receive LED toggles while data is received.
// - Collision LED pin low at reset disables scrambler and descrambler.
// - Collision LED toggles on half-duplex collisions, idle in full duplex.
// - Link LED low on link in MII modes, high in 7-wire, high on bypass detect.
// - Fast speed LED pin low at reset selects fiber operation.
// - Standard style: fast speed LED low at 100 Mbps, high at 10 Mbps.
// - Standard style: transmit LED toggles while transmitting.
// - Slow speed LED pin low at reset enables 25 MHz reference clock output.
// - Standard style: slow speed LED low at 10 Mbps, high at 100 Mbps.
// - Standard style: duplex LED low in full duplex, high in half duplex.
// - Advanced style: LED pin pairs drive two bicolor LEDs.
package slp_pkg;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          BLINK_HALF_NS  = 50000000;
    localparam int          BLINK_CYC      = BLINK_HALF_NS / CLK_PERIOD_NS;
    localparam logic [1:0]  STRAP_WAIT     = 2'h2;
    localparam logic [4:0]  ADDR_CTRL      = 5'h00;
    localparam logic [4:0]  ADDR_STATUS    = 5'h01;
    localparam logic [4:0]  ADDR_ADVERT    = 5'h04;
    localparam logic [4:0]  ADDR_MISC      = 5'h10;
    localparam logic [4:0]  ADDR_IRQ       = 5'h11;
    localparam int          CTRL_SPEED_BIT = 13;
    localparam int          CTRL_AN_BIT    = 12;
    localparam int          CTRL_DPX_BIT   = 8;
    localparam int          STAT_ABIL_LSB  = 11;
    localparam int          STAT_AN_BIT    = 3;
    localparam int          STAT_LINK_BIT  = 2;
    localparam int          ADV_ABIL_LSB   = 5;
    localparam int          MISC_RPT_BIT   = 15;
    localparam int          MISC_POL_BIT   = 14;
    localparam int          MISC_DATA_BIT  = 9;
    localparam int          MISC_DIR_BIT   = 8;
    localparam logic [15:0] MISC_RESET     = 16'h0100;
    localparam logic [1:0]  REFCLK_DIV_TOP = 2'h3;

    // Strap pins, inputs side; the first five are shared with the drive side
    typedef struct packed {
        logic       spare1;
        logic       receive_led;
        logic       collision_led;
        logic       fast_speed_led;
        logic       slow_speed_led;
        logic [2:0] cap_sel;
        logic       autoneg_ability_strap;
        logic       repeater_strap;
    } slp_pins_t;

    // Status from the datapath, same clock
    typedef struct packed {
        logic link_up;
        logic speed100;
        logic full_duplex;
        logic seven_wire;
        logic coding_bypass_mode;
        logic signal_detect;
        logic rx_active;
        logic tx_active;
        logic collision;
    } slp_stat_t;

    // Configuration towards the datapath
    typedef struct packed {
        logic       xfmr_125;
        logic       autoneg_en;
        logic       speed100_sel;
        logic       full_duplex_sel;
        logic [3:0] advert;
        logic       repeater_mode;
        logic       scrambler_en;
        logic       fiber_mode;
        logic       led_advanced;
    } slp_cfg_t;
endpackage : slp_pkg

/* File: bench/slp_board.sv */
// Board model: strap resistors and pin wiring around the shared pins
`timescale 1ns/1ns
module slp_board import slp_pkg::*; (
    // Resistor levels chosen by the bench
    input  wire slp_pins_t  strap,
    // Drive side of the device
    input  wire logic [4:0] pin_out,
    input  wire logic [4:0] pin_oe,
    // Resolved pin levels and management clock
    output slp_pins_t       pins,
    output logic            mgmt_clk
);
    // Unused management clock stays grounded
    assign mgmt_clk = 1'b0;

    // A pin shows its resistor level unless the device drives it
    always_comb begin
        pins = strap;
        if (pin_oe[4]) pins.spare1 = pin_out[4];
        if (pin_oe[3]) pins.receive_led = pin_out[3];
        if (pin_oe[2]) pins.collision_led = pin_out[2];
        if (pin_oe[1]) pins.fast_speed_led = pin_out[1];
        if (pin_oe[0]) pins.slow_speed_led = pin_out[0];
    end
endmodule : slp_board

/* File: bench/strap_latch_and_led_pin_control_tb_top.sv */
// Self-checking bench for the strap latch and LED pin block
`timescale 1ns/1ns
module strap_latch_and_led_pin_control_tb_top import slp_pkg::*;;
    logic        CORE_CLK = 1'b0;
    logic        RST = 1'b1;
    logic [4:0]  reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] rdata, d;
    slp_pins_t   strap = '1;
    slp_pins_t   pins_in, s;
    slp_stat_t   stat = '0;
    logic [7:0]  irq_ev = 8'h00;
    logic [4:0]  pout, poe;
    logic        tx_led, dpx_led, lnk_led, refclk, irq_out, irq_oe;
    slp_cfg_t    cfg;
    logic [7:0]  mask;
    int          err_count = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n;

    // Device under test: short blink, 10 Mbps half duplex abilities, known idle bicolor nibble
    slp_strap_led #(.BLINK_COUNT(4), .CAP_TABLE(32'h1111_1111), .BICOLOR_TAB(64'h0000_0000_0000_0006)) uut (
        .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .PINS_IN(pins_in),
        .PINS_OUT(pout), .PINS_OE(poe), .TRANSMIT_LED(tx_led), .DUPLEX_LED(dpx_led),
        .LINK_LED(lnk_led), .REFCLK_OUT(refclk), .IRQ_OUT(irq_out), .IRQ_OE(irq_oe),
        .STAT(stat), .IRQ_EVENTS(irq_ev), .CFG(cfg));

    // Pins and resistors
    slp_board board (.strap(strap), .pin_out(pout), .pin_oe(poe), .pins(pins_in), .mgmt_clk());

    // Clock and hang guard
    always #5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_cnt(input int got, input int exp);
        compares++;
        if (got != exp) begin
            err_count++;
            $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
        end
    endtask : cmp_cnt

    task automatic tick(input int k);
        repeat (k) @(posedge CORE_CLK);
        #1;
    endtask : tick

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge CORE_CLK);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge CORE_CLK);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge CORE_CLK);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge CORE_CLK);
        reg_rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    // Expected latched configuration from the strap levels
    function automatic logic [15:0] exp_cfg(input slp_pins_t p);
        return 16'({p.spare1, p.autoneg_ability_strap, p.collision_led, ~p.fast_speed_led,
                    ~p.receive_led, p.repeater_strap});
    endfunction : exp_cfg

    function automatic logic pick(input int sel);
        case (sel)
            0: return refclk;
            1: return pout[3];
            2: return pout[2];
            default: return tx_led;
        endcase
    endfunction : pick

    // Counts level changes of one output over 24 cycles
    task automatic count_chg(input int sel, output int c);
        logic prev;
        c = 0;
        prev = pick(sel);
        repeat (24) begin
            tick(1);
            if (pick(sel) !== prev) c++;
            prev = pick(sel);
        end
    endtask : count_chg

    initial begin
        void'($urandom(32'h34e767d1));
        // Hand-picked, random, then standard straps; last one stays for the feature tests
        for (int k = 0; k < 6; k++) begin
            s = (k == 0) ? 10'h200 : (k == 1) ? 10'h1FF : (k == 5) ? 10'h1FE : 10'($urandom);
            @(posedge CORE_CLK);
            RST <= 1'b1;
            strap <= s;
            tick((k == 0) ? 10 : 3);
            cmp_val(16'(poe), 16'h0000);
            @(posedge CORE_CLK);
            RST <= 1'b0;
            tick(6);
            cmp_val(16'({cfg.xfmr_125, cfg.autoneg_en, cfg.scrambler_en, cfg.fiber_mode,
                         cfg.led_advanced, cfg.repeater_mode}), exp_cfg(s));
            cmp_val(16'(poe), 16'h000F);
            // Idle LED levels: standard style at 10 Mbps half duplex, or the bench bicolor nibble
            cmp_val(16'({pout[1], tx_led, pout[0], dpx_led}),
                    s.receive_led ? 16'h000D : 16'h0006);
            count_chg(0, n);
            cmp_cnt(n, s.slow_speed_led ? 0 : 12);
            rd(ADDR_STATUS, d);
            cmp_val(d & 16'h7808, {1'b0, 4'h1, 7'h00, s.autoneg_ability_strap, 3'h0});
        end
        // Writes above the strapped ability are clipped, unmapped place reads zero
        wr(ADDR_CTRL, 16'hFFFF);
        rd(ADDR_CTRL, d);
        cmp_val(d & 16'h3100, 16'h1000);
        wr(ADDR_ADVERT, 16'hFFFF);
        rd(ADDR_ADVERT, d);
        cmp_val(d & 16'h01E0, 16'h0020);
        cmp_val(16'({cfg.speed100_sel, cfg.full_duplex_sel, cfg.advert}), 16'h0001);
        wr(5'h05, 16'hFFFF);
        rd(5'h05, d);
        cmp_val(d, 16'h0000);
        // Repeater by register bit
        wr(ADDR_MISC, 16'h8100);
        rd(ADDR_MISC, d);
        cmp_val({d & 16'hC100, 15'h0, cfg.repeater_mode}, {16'h8100, 16'h0001});
        // Spare pin as input, then as output
        for (int v = 0; v < 2; v++) begin
            @(posedge CORE_CLK);
            strap.spare1 <= v[0];
            wr(ADDR_MISC, 16'h0100);
            tick(4);
            rd(ADDR_MISC, d);
            cmp_val({d & 16'h0300, 14'h0, cfg.repeater_mode, poe[4]}, {6'h0, v[0], 9'h100, 16'h0});
            wr(ADDR_MISC, {6'h0, v[0], 9'h000});
            tick(1);
            cmp_val(16'({poe[4], pout[4]}), {14'h0, 1'b1, v[0]});
        end
        // Every event line, random enables, polarity alternating
        mask = 8'($urandom) | 8'h01;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_MISC, {1'b0, i[0], 14'h0100});
            wr(ADDR_IRQ, {8'hFF, mask});
            @(posedge CORE_CLK);
            irq_ev <= 8'h01 << i;
            @(posedge CORE_CLK);
            irq_ev <= 8'h00;
            tick(2);
            cmp_val(16'({irq_oe, irq_out}), {14'h0, mask[i], i[0]});
            rd(ADDR_IRQ, d);
            cmp_val(d, {8'h01 << i, mask});
            wr(ADDR_IRQ, {8'hFF, mask});
            tick(1);
            cmp_val(16'(irq_oe), 16'h0000);
        end
        // Standard LED levels for every speed, duplex and link mode
        for (int j = 0; j < 8; j++) begin
            @(posedge CORE_CLK);
            stat <= '{link_up: 1'b1, speed100: j[0], full_duplex: j[1], seven_wire: j[2], default: 1'b0};
            tick(3);
            cmp_val(16'({pout[1:0], dpx_led, lnk_led}), 16'({~j[0], j[0], ~j[1], j[2]}));
        end
        @(posedge CORE_CLK);
        stat <= '{coding_bypass_mode: 1'b1, signal_detect: 1'b1, default: 1'b0};
        tick(3);
        cmp_val(16'(lnk_led), 16'h0001);
        // Activity blinks in half duplex, then silence in full duplex
        @(posedge CORE_CLK);
        stat <= '{link_up: 1'b1, rx_active: 1'b1, tx_active: 1'b1, collision: 1'b1, default: 1'b0};
        // Let the LEDs leave their idle level before counting
        tick(2);
        for (int sel = 1; sel < 4; sel++) begin
            count_chg(sel, n);
            cmp_cnt(n, 6);
        end
        @(posedge CORE_CLK);
        stat <= '{link_up: 1'b1, full_duplex: 1'b1, collision: 1'b1, default: 1'b0};
        tick(8);
        for (int sel = 1; sel < 4; sel++) begin
            count_chg(sel, n);
            cmp_cnt(n, 0);
        end
        tally_and_finish();
    end
endmodule : strap_latch_and_led_pin_control_tb_top
